// file: logic/pmd_pkg.sv
// package for the peripheral clock gating block
// shared by the top and the property checker; no bus, one clock
package pmd_pkg;
  localparam int          NUM_PERIPH      = 8;
  localparam logic [7:0]  PRESENT_RESET   = 8'hff;
  localparam logic [7:0]  GATE_BITS_RESET = 8'h00;
  // one instruction cycle, in system clock cycles
  localparam int          INSTR_CYCLES    = 1;

  typedef struct packed {
    logic       wr;
    logic [7:0] data;
  } gate_write_type;

  typedef struct packed {
    logic [7:0] enabled;
    logic [7:0] clk_en;
  } periph_ctl_type;
endpackage

// file: logic/clock_gate_cell.sv
// glitch-free clock gate for one peripheral
// assumes a latch-based gate is inferred; the latched enable changes only while clk is low
`timescale 1ns/1ps
module clock_gate_cell (
  // clock
  input  wire logic clk,
  // control
  input  wire logic enable,
  // gated clock
  output logic      gclk
);
  logic en_latch;

  // latch is transparent while clk is low, so the gate never cuts a high phase
  always_latch begin
    if (!clk) begin
      en_latch <= enable;
    end
  end

  assign gclk = clk & en_latch;
endmodule

// file: logic/peripheral_module_disable.sv
// peripheral module disable: per-peripheral clock gating and register fencing
// assumes software writes come as a one-cycle strobe on the system clock
// How it works
// - a set disable bit stops every clock going to that peripheral.
// - while disabled, writes to the peripheral's registers are blocked and its reads are not trusted.
// - a peripheral counts as enabled only when its bit is clear and it exists on this variant.
// - after reset the disable bits of present peripherals are clear, so they start enabled; absent lanes start set.
// - a newly set bit disables the peripheral one instruction cycle later.
// - a newly cleared bit re-enables the peripheral one instruction cycle later with its old settings.
`timescale 1ns/1ps
module peripheral_module_disable
  import pmd_pkg::*;
#(
  parameter int               N       = NUM_PERIPH,
  parameter logic [N-1:0]     PRESENT = PRESENT_RESET
) (
  // clock and reset
  input  wire logic           clk,
  input  wire logic           resetn,
  // software side
  input  pmd_pkg::gate_write_type gate_write,
  output logic [N-1:0]        peripheral_clock_gate_bits,
  // peripheral register access
  input  wire logic [N-1:0]   periph_reg_wr,
  input  wire logic [N-1:0]   periph_reg_rd,
  output logic [N-1:0]        periph_reg_wr_allowed,
  output logic [N-1:0]        periph_rd_valid,
  // gated peripheral clocks and status
  output logic [N-1:0]        periph_clk,
  output pmd_pkg::periph_ctl_type periph_ctl
);
  import pmd_pkg::*;

  // lag depth in system clocks; a count below one would leave no stage at all
  localparam int           LAG           = (INSTR_CYCLES < 1) ? 1 : INSTR_CYCLES;

  // lanes that do not exist on this variant
  localparam logic [N-1:0] ABSENT        = ~PRESENT;

  // absent lanes come out of reset gated, present ones clear
  localparam logic [N-1:0] BITS_AT_RESET = N'(GATE_BITS_RESET) | ABSENT;

  // present lanes come out of reset running
  localparam logic [N-1:0] EN_AT_RESET   = N'(PRESENT_RESET) & PRESENT;

  // width of one status field of the carrier
  localparam int           CTL_W         = $bits(periph_ctl_type) / 2;

  // absent lanes always read as gated, whatever software writes
  function automatic logic [N-1:0] force_absent(
    input logic [N-1:0] bits
  );
    begin
      force_absent = bits | ABSENT;
    end
  endfunction

  // a lane may run only when its bit is clear and the lane exists
  function automatic logic [N-1:0] lane_enable(
    input logic [N-1:0] bits
  );
    begin
      lane_enable = ~bits & PRESENT;
    end
  endfunction

  // one request passes only while its peripheral is enabled
  function automatic logic fence(
    input logic req,
    input logic en
  );
    begin
      fence = req & en;
    end
  endfunction

  // software write, split out of the carrier
  logic             write_strobe;
  logic [N-1:0]     write_bits;
  logic [N-1:0]     write_masked;

  // disable bits
  logic [N-1:0]     gate_bits_ff;
  logic [N-1:0]     nxt_gate_bits;

  // enable pipeline, one stage per system clock of lag
  logic [N-1:0]     want_enabled;
  logic [N-1:0]     lag_ff [LAG];
  logic [N-1:0]     nxt_lag [LAG];
  logic [N-1:0]     enabled;

  // register fencing
  logic [N-1:0]     wr_pass;
  logic [N-1:0]     rd_pass;

  // gated clocks
  logic [N-1:0]     gated_clk;

  // status, fitted to the carrier's field width
  logic [CTL_W-1:0] ctl_enabled;

  assign write_strobe = gate_write.wr;

  assign write_bits   = gate_write.data[N-1:0];

  // only present lanes hold a writable bit
  assign write_masked = force_absent(write_bits);

  // the lag starts from the stored bits, so a write shows in the bits first
  assign want_enabled = lane_enable(gate_bits_ff);

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gen_lane

      // a write replaces the bit, otherwise it holds
      assign nxt_gate_bits[g] = write_strobe ? write_masked[g] : gate_bits_ff[g];

      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          gate_bits_ff[g] <= BITS_AT_RESET[g];
        end else begin
          gate_bits_ff[g] <= nxt_gate_bits[g];
        end
      end

      // a fenced write never reaches the lane's registers
      assign wr_pass[g] = fence(periph_reg_wr[g], enabled[g]);

      // reads of a fenced lane are flagged invalid; the data itself is not forced
      assign rd_pass[g] = fence(periph_reg_rd[g], enabled[g]);

      // the gate closes only in the low phase, so no high pulse is cut short
      clock_gate_cell u_gate (
        .clk    (clk),
        .enable (enabled[g]),
        .gclk   (gated_clk[g])
      );

    end
  endgenerate

  genvar s;
  generate
    for (s = 0; s < LAG; s++) begin : gen_stage

      if (s == 0) begin : g_first
        assign nxt_lag[s] = want_enabled;
      end else begin : g_rest
        assign nxt_lag[s] = lag_ff[s-1];
      end

      // the same stages serve both directions, so set and clear lag alike
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          lag_ff[s] <= EN_AT_RESET;
        end else begin
          lag_ff[s] <= nxt_lag[s];
        end
      end

    end
  endgenerate

  assign enabled = lag_ff[LAG-1];

  assign peripheral_clock_gate_bits = gate_bits_ff;

  assign periph_reg_wr_allowed      = wr_pass;

  assign periph_rd_valid            = rd_pass;

  assign periph_clk                 = gated_clk;

  // lanes beyond the field width are not reported
  assign ctl_enabled                = CTL_W'(enabled);

  assign periph_ctl.enabled         = ctl_enabled;

  assign periph_ctl.clk_en          = ctl_enabled;
endmodule

// file: test/gate_properties.sv
// port assertions for the gate block
// assumes all eight peripherals present
`timescale 1ns/1ps
module gate_properties import pmd_pkg::*; (
  input wire logic clk, resetn,
  input gate_write_type gate_write,
  input wire logic [7:0] peripheral_clock_gate_bits, periph_reg_wr, periph_reg_rd,
  input wire logic [7:0] periph_reg_wr_allowed, periph_rd_valid, periph_clk,
  input periph_ctl_type periph_ctl);
  wire [7:0] b = peripheral_clock_gate_bits, e = periph_ctl.enabled;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_bits_wr: assert property (gate_write.wr |=> b == $past(gate_write.data)) else $error("bits");
  a_en_lag: assert property (e == ~$past(b)) else $error("lag");
  a_wr_fence: assert property (periph_reg_wr_allowed == (periph_reg_wr & e)) else $error("wr");
  a_rd_fence: assert property (periph_rd_valid == (periph_reg_rd & e)) else $error("rd");
  a_gate_en: assert property (periph_ctl.clk_en == e) else $error("gate");
  a_clk_stop: assert property (@(negedge clk) periph_clk == $past(periph_ctl.clk_en)) else $error("clk");
  a_rst_clear: assert property ($rose(resetn) |-> b == 8'h00 && e == 8'hff) else $error("rst");
endmodule
bind peripheral_module_disable gate_properties i_chk (.*);

// file: test/periph_stub.sv
// stand-in peripherals: a flag flips on each rising gated clock edge
// assumes one gated clock per peripheral
`timescale 1ns/1ps
module periph_stub (input wire logic [7:0] gclk, output logic [7:0] tog);
  for (genvar i = 0; i < 8; i++) begin : g_p
    logic t = 1'b0;
    always @(posedge gclk[i]) t <= !t;
    assign tog[i] = t;
  end
endmodule

// file: test/tb_peripheral_module_disable.sv
// random gate writes and register traffic against a cycle model
// assumes one instruction cycle per clock
`timescale 1ns/1ps
module tb_peripheral_module_disable;
  logic clk = 0, resetn = 0;
  logic [8:0] gw = 9'h000;
  logic [7:0] wr = 0, rd = 0, bits, ok, rv, gclk, tog, last, bm = 0, em = 8'hff, pe;
  logic [15:0] pc;
  int n_errors = 0, checked = 0;
  peripheral_module_disable i_peripheral_module_disable (.clk, .resetn, .gate_write(gw),
    .peripheral_clock_gate_bits(bits), .periph_reg_wr(wr), .periph_reg_rd(rd),
    .periph_reg_wr_allowed(ok), .periph_rd_valid(rv), .periph_clk(gclk), .periph_ctl(pc));
  periph_stub i_periph_stub (.gclk, .tog);
  initial forever #25 clk = ~clk;
  task automatic chk(input logic [7:0] got, exp);
    checked++;
    n_errors += int'(got !== exp);
    if (got !== exp) $display("[FAIL] %0t %h %h", $time, got, exp);
  endtask
  task automatic end_sim;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #100us n_errors++;
    end_sim;
  end
  initial begin
    void'($urandom(28611));
    repeat (6) @(posedge clk);
    resetn <= 1;
    #1 last = tog;
    repeat (500) begin
      @(posedge clk);
      pe = em;
      em = ~bm;
      if (gw[8]) bm = gw[7:0];
      {gw, wr, rd} <= 25'($urandom);
      #1 chk(tog ^ last, pe);
      chk(bits, bm);
      chk(ok, wr & em);
      chk(rv, rd & em);
      chk(pc[15:8], em);
      chk(pc[7:0], em);
      last = tog;
    end
    end_sim;
  end
endmodule
